/* dot_dram_end.sv */
// dram end: odt mode selection and termination timing
//
// Behaviour
// - async odt when dll stopped in powerdown
// - async odt while dll relocks after dll_reset, unless termination turns on mid-relock
// - async path skips additive latency delay
// - async turn-on within one cycle of odt
// - async turn-off within one cycle of odt
// - transition windows only with dll-off powerdown
// - entry window ends when cke registered low
// - anticipation interval equals write latency minus one
// - refresh in progress extends entry window
// - entry-window assertion may be sync or async
// - entry-window deassertion may be sync or async
// - exit window ends xpdll after cke high
// - exit-window changes may be sync or async
// - short cke low: async until exit ends
// - short cke high: straight back to async
// - sync odt when dll locked and enabled
// - sync latency is cwl plus al minus two
`include "dot_regs.svh"
`timescale 1ns/10ps
module dot_dram_end #(
  parameter int RFC_CYC = `DOT_RFC_CYC,
  parameter int XPDLL_CYC = `DOT_XPDLL_CYC,
  parameter int DLLK_CYC = `DOT_DLLK_CYC,
  parameter int LINE_DEPTH = 32
) (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  // link from the controller
  dot_link_if.dram link,
  // mode register contents
  input wire logic dll_enable,
  input wire logic dll_pd_keep,
  input wire logic rtt_enable,
  input wire dot_pkg::dot_lat_t cwl,
  input wire dot_pkg::dot_lat_t al,
  input wire logic dll_reset,
  // termination state
  output logic rtt_on,
  output logic async_mode,
  output logic entry_window,
  output logic exit_window
);
  localparam logic [4:0] ASYNC_TAP = 5'(`DOT_ASYNC_CYC - 1);
  localparam logic [9:0] RFC_LOAD = 10'(RFC_CYC);
  localparam logic [9:0] XPDLL_LOAD = 10'(XPDLL_CYC);
  localparam logic [9:0] DLLK_LOAD = 10'(DLLK_CYC);

  dot_pkg::dot_dram_state_e state_reg;
  dot_pkg::dot_dram_state_e state_next;
  logic relock_reg;
  logic relock_next;
  logic [9:0] lock_cnt_reg;
  logic [9:0] lock_cnt_next;
  logic [9:0] rfc_cnt_reg;
  logic [9:0] rfc_cnt_next;
  logic from_reset_reg;
  logic from_reset_next;
  logic cke_q_reg;
  logic cke_q_next;
  logic rtt_reg;
  logic rtt_next;
  logic [4:0] tap;
  logic line_out;
  logic enabled;
  logic cke_low;
  logic is_async;

  // write latency less two clocks, in cycles
  function automatic logic [4:0] odt_latency(input dot_pkg::dot_lat_t c,
                                             input dot_pkg::dot_lat_t a);
    logic [4:0] wl;
    wl = 5'(c) + 5'(a);
    return (wl > 5'h02) ? 5'(wl - 5'h02) : 5'h01;
  endfunction

  assign enabled = dll_enable & rtt_enable;
  // cke as registered at this edge
  assign cke_low = ~link.cke;

  // refresh busy timer
  always_comb
  begin
    rfc_cnt_next = rfc_cnt_reg;
    if (link.refresh_cmd)
      rfc_cnt_next = RFC_LOAD;
    else if (rfc_cnt_reg != 10'h000)
      rfc_cnt_next = 10'(rfc_cnt_reg - 10'h001);
  end

  // mode selection
  always_comb
  begin
    state_next = state_reg;
    relock_next = relock_reg;
    lock_cnt_next = lock_cnt_reg;
    from_reset_next = from_reset_reg;
    cke_q_next = link.cke;
    if (relock_reg && lock_cnt_reg != 10'h000)
      lock_cnt_next = 10'(lock_cnt_reg - 10'h001);
    if (relock_reg && lock_cnt_reg <= 10'h001)
    begin
      relock_next = 1'b0;
      from_reset_next = 1'b0;
    end
    if (dll_reset)
    begin
      relock_next = 1'b1;
      from_reset_next = 1'b1;
      lock_cnt_next = DLLK_LOAD;
    end
    case (state_reg)
      dot_pkg::DS_OFF:
      begin
        if (enabled)
          state_next = dot_pkg::DS_SYNC;
      end
      dot_pkg::DS_SYNC:
      begin
        if (!enabled)
          state_next = dot_pkg::DS_OFF;
        else if (cke_low && !dll_pd_keep && !from_reset_reg)
        begin
          // entry stays synchronous until a running refresh completes
          if (rfc_cnt_reg > 10'h001)
            state_next = dot_pkg::DS_ENTRY;
          else
            state_next = dot_pkg::DS_ASYNC;
        end
      end
      dot_pkg::DS_ENTRY:
      begin
        if (!enabled)
          state_next = dot_pkg::DS_OFF;
        else if (!cke_low)
        begin
          // short low pulse: exit begins before entry has ended
          state_next = dot_pkg::DS_ASYNC;
          relock_next = 1'b1;
          lock_cnt_next = XPDLL_LOAD;
        end
        else if (rfc_cnt_reg <= 10'h001)
          state_next = dot_pkg::DS_ASYNC;
      end
      dot_pkg::DS_ASYNC:
      begin
        if (!enabled)
          state_next = dot_pkg::DS_OFF;
        else if (relock_reg && !from_reset_reg && cke_low && !dll_pd_keep)
        begin
          // short high pulse: dll never relocked, stay asynchronous
          relock_next = 1'b0;
        end
        else if (relock_reg && lock_cnt_reg <= 10'h001)
          state_next = dot_pkg::DS_SYNC;
        else if (!relock_reg && !cke_low && cke_q_reg == 1'b0)
        begin
          relock_next = 1'b1;
          lock_cnt_next = XPDLL_LOAD;
        end
      end
      default:
      begin
        state_next = dot_pkg::DS_OFF;
      end
    endcase
    // a dll reset forces asynchronous handling wherever termination is on
    if (dll_reset && enabled)
      state_next = dot_pkg::DS_ASYNC;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      state_reg <= dot_pkg::DS_OFF;
      relock_reg <= 1'b1;
      lock_cnt_reg <= DLLK_LOAD;
      from_reset_reg <= 1'b1;
      rfc_cnt_reg <= 10'h000;
      cke_q_reg <= 1'b1;
    end
    else if (ce)
    begin
      state_reg <= state_next;
      relock_reg <= relock_next;
      lock_cnt_reg <= lock_cnt_next;
      from_reset_reg <= from_reset_next;
      rfc_cnt_reg <= rfc_cnt_next;
      cke_q_reg <= cke_q_next;
    end
  end

  // clocked latency wants a locked dll; async while relocking in DS_OFF, but DS_OFF moves to DS_SYNC without waiting for the lock
  assign is_async = (state_reg == dot_pkg::DS_ASYNC) ||
                    (state_reg == dot_pkg::DS_OFF && relock_reg);

  // one line serves both paths; only the tap moves on a mode change,
  // so an edge already in flight may land early or late, which the
  // transition windows allow
  always_comb
  begin
    if (is_async)
      tap = ASYNC_TAP;
    else
      tap = 5'(odt_latency(cwl, al) - 5'h01);
  end

  dot_delay_line #(
    .DEPTH(LINE_DEPTH)
  ) dot_delay_line_i (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ce(ce),
    .din(link.odt),
    .tap(tap),
    .dout(line_out)
  );

  always_comb
  begin
    rtt_next = 1'b0;
    if (state_reg != dot_pkg::DS_OFF)
      rtt_next = line_out;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      rtt_reg <= 1'b0;
    else if (ce)
      rtt_reg <= rtt_next;
  end

  assign rtt_on = rtt_reg;
  assign async_mode = is_async;
  assign entry_window = (state_reg == dot_pkg::DS_ENTRY);
  assign exit_window = relock_reg & ~from_reset_reg;
endmodule

/* dot_regs.svh */
// constants for the odt power-down transition blocks
`ifndef DOT_REGS_SVH
`define DOT_REGS_SVH

// controller register byte offsets
`define DOT_CTRL_OFS 8'h00
`define DOT_TIMING_OFS 8'h04
`define DOT_STATUS_OFS 8'h08

// control register fields
`define DOT_CTRL_ODT_BIT 0
`define DOT_CTRL_PDREQ_BIT 1
`define DOT_CTRL_REFRESH_BIT 2
`define DOT_CTRL_DLLKEEP_BIT 3

// timing register fields
`define DOT_TIMING_CWL_LSB 0
`define DOT_TIMING_AL_LSB 4

// reset values
`define DOT_CTRL_RST 4'h0
`define DOT_CWL_RST 4'h5
`define DOT_AL_RST 4'h0

// clock period and asynchronous termination delays, in ps
`define DOT_CLK_PS 50000
`define DOT_ASYNC_ON_MIN_PS 2000
`define DOT_ASYNC_ON_MAX_PS 8500
`define DOT_ASYNC_OFF_MIN_PS 2000
`define DOT_ASYNC_OFF_MAX_PS 8500
// least delay rounds up, longest rounds down, never under one cycle
`define DOT_ASYNC_MIN_CYC ((`DOT_ASYNC_ON_MIN_PS + `DOT_CLK_PS - 1) / `DOT_CLK_PS)
`define DOT_ASYNC_MAX_RAW (`DOT_ASYNC_ON_MAX_PS / `DOT_CLK_PS)
`define DOT_ASYNC_CYC ((`DOT_ASYNC_MAX_RAW < 1) ? 1 : `DOT_ASYNC_MAX_RAW)

// default cycle counts for refresh, dll relock and dll reset lock
`define DOT_RFC_CYC 8
`define DOT_XPDLL_CYC 24
`define DOT_DLLK_CYC 32

`endif

/* dot_pkg.sv */
// types shared by the odt transition ends
package dot_pkg;
  typedef logic [3:0] dot_lat_t;

  typedef enum logic [1:0] {
    DS_OFF = 2'b00,
    DS_SYNC = 2'b01,
    DS_ENTRY = 2'b10,
    DS_ASYNC = 2'b11
  } dot_dram_state_e;

  typedef enum logic [2:0] {
    CS_UP = 3'b000,
    CS_ENTRY = 3'b001,
    CS_DOWN = 3'b010,
    CS_EXIT_PRE = 3'b011,
    CS_EXIT_POST = 3'b100
  } dot_ctrl_state_e;
endpackage

/* dot_link_if.sv */
// link between memory controller and dram odt logic
`timescale 1ns/10ps
interface dot_link_if;
  logic odt;
  logic cke;
  logic refresh_cmd;
  logic powerdown_entry_window;
  logic powerdown_exit_window;

  modport ctrl (
    output odt,
    output cke,
    output refresh_cmd,
    output powerdown_entry_window,
    output powerdown_exit_window
  );

  modport dram (
    input odt,
    input cke,
    input refresh_cmd,
    input powerdown_entry_window,
    input powerdown_exit_window
  );
endinterface

/* dot_delay_line.sv */
// tapped shift line for the odt latency path
`timescale 1ns/10ps
module dot_delay_line #(
  parameter int DEPTH = 16
) (
  // clock and control
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  // data
  input wire logic din,
  input wire logic [4:0] tap,
  output logic dout
);
  logic [DEPTH-1:0] line_reg;
  logic [DEPTH-1:0] line_next;

  always_comb
  begin
    line_next = {line_reg[DEPTH-2:0], din};
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      line_reg <= '0;
    else if (ce)
      line_reg <= line_next;
  end

  // out-of-range taps read the oldest stage rather than x
  always_comb
  begin
    if (32'(tap) < DEPTH)
      dout = line_reg[tap];
    else
      dout = line_reg[DEPTH-1];
  end
endmodule

/* dot_ctrl_end.sv */
// controller end: ahb-lite registers, cke sequencing and odt drive
`include "dot_regs.svh"
`timescale 1ns/10ps
module dot_ctrl_end #(
  parameter int RFC_CYC = `DOT_RFC_CYC,
  parameter int XPDLL_CYC = `DOT_XPDLL_CYC
) (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // link to the dram
  dot_link_if.ctrl link
);
  localparam logic [9:0] RFC_LOAD = 10'(RFC_CYC);
  localparam logic [9:0] XPDLL_LOAD = 10'(XPDLL_CYC);

  dot_pkg::dot_ctrl_state_e state_reg;
  dot_pkg::dot_ctrl_state_e state_next;
  logic [9:0] cnt_reg;
  logic [9:0] cnt_next;
  logic [9:0] rfc_cnt_reg;
  logic [9:0] rfc_cnt_next;
  logic entry_ext_reg;
  logic entry_ext_next;
  logic cke_reg;
  logic cke_next;
  logic [3:0] ctrl_reg;
  logic [3:0] ctrl_next;
  logic [7:0] timing_reg;
  logic [7:0] timing_next;
  logic refresh_reg;
  logic refresh_next;
  logic wr_pend_reg;
  logic wr_pend_next;
  logic [7:0] addr_reg;
  logic [7:0] addr_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic take;
  logic [9:0] lead_cyc;
  logic [31:0] status;

  assign take = hsel & htrans[1] & hready;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  // write latency less one clock
  assign lead_cyc = 10'(5'(timing_reg[7:4]) + 5'(timing_reg[3:0]) - 5'h01);
  assign status = {24'h000000, 1'b0, state_reg, rfc_cnt_reg != 10'h000,
                   link.powerdown_exit_window, link.powerdown_entry_window, cke_reg};

  // register slave; reads are captured in the address phase
  always_comb
  begin
    ctrl_next = ctrl_reg;
    timing_next = timing_reg;
    refresh_next = 1'b0;
    wr_pend_next = take & hwrite;
    addr_next = take ? haddr[7:0] : addr_reg;
    rdata_next = rdata_reg;
    if (take && !hwrite)
    begin
      case (haddr[7:0])
        `DOT_CTRL_OFS: rdata_next = {28'h0000000, ctrl_reg};
        `DOT_TIMING_OFS: rdata_next = {24'h000000, timing_reg};
        `DOT_STATUS_OFS: rdata_next = status;
        default: rdata_next = 32'h00000000;
      endcase
    end
    if (wr_pend_reg)
    begin
      case (addr_reg)
        `DOT_CTRL_OFS:
        begin
          ctrl_next = hwdata[3:0];
          ctrl_next[`DOT_CTRL_REFRESH_BIT] = 1'b0;
          // refresh only while cke is high
          refresh_next = hwdata[`DOT_CTRL_REFRESH_BIT] & cke_reg;
        end
        `DOT_TIMING_OFS: timing_next = hwdata[7:0];
        default: ctrl_next = ctrl_reg;
      endcase
    end
  end

  // cke sequencer with anticipation windows
  always_comb
  begin
    state_next = state_reg;
    cnt_next = (cnt_reg != 10'h000) ? 10'(cnt_reg - 10'h001) : cnt_reg;
    cke_next = cke_reg;
    rfc_cnt_next = refresh_reg ? RFC_LOAD :
                   (rfc_cnt_reg != 10'h000) ? 10'(rfc_cnt_reg - 10'h001) : rfc_cnt_reg;
    entry_ext_next = entry_ext_reg & (rfc_cnt_reg > 10'h001);
    case (state_reg)
      dot_pkg::CS_UP:
      begin
        if (ctrl_reg[`DOT_CTRL_PDREQ_BIT])
        begin
          if (ctrl_reg[`DOT_CTRL_DLLKEEP_BIT])
          begin
            cke_next = 1'b0;
            state_next = dot_pkg::CS_DOWN;
          end
          else
          begin
            state_next = dot_pkg::CS_ENTRY;
            cnt_next = lead_cyc;
          end
        end
      end
      dot_pkg::CS_ENTRY:
      begin
        if (cnt_reg <= 10'h001)
        begin
          cke_next = 1'b0;
          entry_ext_next = (rfc_cnt_reg > 10'h001);
          state_next = dot_pkg::CS_DOWN;
        end
      end
      dot_pkg::CS_DOWN:
      begin
        if (!ctrl_reg[`DOT_CTRL_PDREQ_BIT])
        begin
          if (ctrl_reg[`DOT_CTRL_DLLKEEP_BIT])
          begin
            cke_next = 1'b1;
            state_next = dot_pkg::CS_UP;
          end
          else
          begin
            state_next = dot_pkg::CS_EXIT_PRE;
            cnt_next = lead_cyc;
          end
        end
      end
      dot_pkg::CS_EXIT_PRE:
      begin
        if (cnt_reg <= 10'h001)
        begin
          cke_next = 1'b1;
          state_next = dot_pkg::CS_EXIT_POST;
          cnt_next = XPDLL_LOAD;
        end
      end
      dot_pkg::CS_EXIT_POST:
      begin
        if (cnt_reg <= 10'h001)
          state_next = dot_pkg::CS_UP;
      end
      default:
      begin
        state_next = dot_pkg::CS_UP;
      end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      state_reg <= dot_pkg::CS_UP;
      cnt_reg <= 10'h000;
      rfc_cnt_reg <= 10'h000;
      entry_ext_reg <= 1'b0;
      cke_reg <= 1'b1;
      ctrl_reg <= `DOT_CTRL_RST;
      timing_reg <= {`DOT_AL_RST, `DOT_CWL_RST};
      refresh_reg <= 1'b0;
      wr_pend_reg <= 1'b0;
      addr_reg <= 8'h00;
      rdata_reg <= 32'h00000000;
    end
    else if (ce)
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      rfc_cnt_reg <= rfc_cnt_next;
      entry_ext_reg <= entry_ext_next;
      cke_reg <= cke_next;
      ctrl_reg <= ctrl_next;
      timing_reg <= timing_next;
      refresh_reg <= refresh_next;
      wr_pend_reg <= wr_pend_next;
      addr_reg <= addr_next;
      rdata_reg <= rdata_next;
    end
  end

  assign hrdata = rdata_reg;
  assign link.odt = ctrl_reg[`DOT_CTRL_ODT_BIT];
  assign link.cke = cke_reg;
  assign link.refresh_cmd = refresh_reg;
  // software must not rely on exact termination timing while set
  assign link.powerdown_entry_window = (state_reg == dot_pkg::CS_ENTRY) | entry_ext_reg;
  assign link.powerdown_exit_window = (state_reg == dot_pkg::CS_EXIT_PRE) |
                                      (state_reg == dot_pkg::CS_EXIT_POST);
endmodule

/* dot_link_assertions.sv */
// link-side checks of the powerdown entry and exit windows
`timescale 1ns/10ps
module dot_link_assertions #(
  parameter int RFC_CYC = 8,
  parameter int XPDLL_CYC = 24
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // link signals
  input wire logic odt,
  input wire logic cke,
  input wire logic refresh_cmd,
  input wire logic powerdown_entry_window,
  input wire logic powerdown_exit_window
);
  int since_ref_reg;
  int since_ref_next;
  int exit_cnt_reg;
  int exit_cnt_next;

  // saturates so a long idle stretch cannot wrap
  always_comb
  begin
    since_ref_next = since_ref_reg > RFC_CYC ? since_ref_reg : since_ref_reg + 1;
    if (refresh_cmd)
      since_ref_next = 0;
    exit_cnt_next = (powerdown_exit_window && cke) ? exit_cnt_reg + 1 : 0;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      since_ref_reg <= RFC_CYC + 1;
      exit_cnt_reg <= 0;
    end
    else
    begin
      since_ref_reg <= since_ref_next;
      exit_cnt_reg <= exit_cnt_next;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // anticipation of 4 holds while timing stays at cwl 5, al 0
  a_entry_anpd: assert property ($rose(powerdown_entry_window) |-> cke[*4] ##1 !cke)
    else $error("entry window length wrong");
  a_entry_start: assert property ($rose(powerdown_entry_window) |-> cke)
    else $error("entry window began with cke low");
  a_entry_bound: assert property ($fell(cke) |-> ##[0:RFC_CYC] !powerdown_entry_window)
    else $error("entry window outlived cke low");
  a_entry_refresh: assert property (
    powerdown_entry_window && !cke |-> since_ref_reg < RFC_CYC)
    else $error("entry window held with no refresh busy");
  a_exit_pre: assert property ($rose(powerdown_exit_window) |-> !cke[*4] ##1 cke)
    else $error("exit window lead wrong");
  a_exit_post: assert property ($fell(powerdown_exit_window) |-> exit_cnt_reg == XPDLL_CYC)
    else $error("exit window tail wrong");
  a_refresh_pulse: assert property (refresh_cmd |-> cke ##1 !refresh_cmd)
    else $error("refresh pulse malformed");
  // windows may overlap only while a refresh keeps the entry window open
  a_no_overlap: assert property (
    powerdown_entry_window && powerdown_exit_window |-> since_ref_reg < RFC_CYC)
    else $error("entry and exit windows overlap with no refresh busy");

  c_entry_done: cover property ($fell(powerdown_entry_window) && !cke);
  c_exit_done: cover property ($fell(powerdown_exit_window) && cke);
  c_refresh_hold: cover property (powerdown_entry_window && !cke);
  c_short_low: cover property (powerdown_entry_window && powerdown_exit_window);
  c_odt_asleep: cover property (!cke && $rose(odt));
endmodule

/* dram_odt_async_transition_bench.sv */
// bench joining controller and dram ends over the odt link
`timescale 1ns/10ps
module dram_odt_async_transition_bench;
  localparam int RFC = 16;
  localparam int XPD = 4;
  localparam int DLLK = 8;
  typedef struct {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic odt;
  } dot_row_s;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic dll_pd_keep = 1'b0;
  logic dll_reset = 1'b0;
  logic rtt_en = 1'b1;
  dot_pkg::dot_lat_t cwl = 4'h5;
  dot_pkg::dot_lat_t al = 4'h0;
  logic rtt_on;
  logic async_mode;
  logic entry_window;
  logic exit_window;
  int bad_count = 0;
  int compares = 0;
  int cycles = 0;
  int win_seen = 0;
  int n;
  logic [31:0] rd;
  dot_row_s rows [5] = '{'{8'h04, 32'h05, 32'h05, 1'b0}, '{8'h0c, 32'hff, 32'h0, 1'b0},
    '{8'h00, 32'h1, 32'h1, 1'b1}, '{8'h00, 32'h4, 32'h0, 1'b0}, '{8'h00, 32'h0, 32'h0, 1'b0}};

  dot_link_if dot_link_if_i ();
  dot_ctrl_end #(.RFC_CYC(RFC), .XPDLL_CYC(XPD)) dot_ctrl_end_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .ce(1'b1), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .link(dot_link_if_i));
  dot_dram_end #(.RFC_CYC(RFC), .XPDLL_CYC(XPD), .DLLK_CYC(DLLK)) dot_dram_end_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .ce(1'b1), .link(dot_link_if_i),
    .dll_enable(1'b1), .dll_pd_keep(dll_pd_keep), .rtt_enable(rtt_en), .cwl(cwl), .al(al),
    .dll_reset(dll_reset), .rtt_on(rtt_on), .async_mode(async_mode),
    .entry_window(entry_window), .exit_window(exit_window));
  dot_link_assertions #(.RFC_CYC(RFC), .XPDLL_CYC(XPD)) dot_link_assertions_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .odt(dot_link_if_i.odt), .cke(dot_link_if_i.cke),
    .refresh_cmd(dot_link_if_i.refresh_cmd),
    .powerdown_entry_window(dot_link_if_i.powerdown_entry_window),
    .powerdown_exit_window(dot_link_if_i.powerdown_exit_window));

  always #25 ref_clk = ~ref_clk;

  always @(posedge ref_clk)
  begin
    cycles++;
    if (dot_link_if_i.powerdown_entry_window || dot_link_if_i.powerdown_exit_window)
      win_seen++;
    if (cycles == 20000)
    begin
      bad_count++;
      test_done();
    end
  end

  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_cnt(input string what, input int exp, input int got);
    compares++;
    if (got != exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  // one single transfer; read data lands in rd
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  function automatic logic sig(input int i);
    case (i)
      0: return dot_link_if_i.odt;
      1: return dot_link_if_i.cke;
      2: return dot_link_if_i.powerdown_entry_window;
      3: return dot_link_if_i.powerdown_exit_window;
      4: return rtt_on;
      6: return entry_window;
      default: return async_mode;
    endcase
  endfunction

  // counts edges until the signal shows v, settled 1 ns after each edge
  task automatic wait_sig(input int i, input logic v);
    #1;
    n = 0;
    while (sig(i) !== v && n < 400)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
  endtask

  // odt up then down; edge count includes the sampling edge itself
  task automatic lat(input logic [31:0] ctrl, input int exp);
    ahb(1'b1, 8'h00, ctrl | 32'h1);
    wait_sig(0, 1'b1);
    wait_sig(4, 1'b1);
    chk_cnt("rtt on delay", exp + 1, n);
    ahb(1'b1, 8'h00, ctrl);
    wait_sig(0, 1'b0);
    wait_sig(4, 1'b0);
    chk_cnt("rtt off delay", exp + 1, n);
  endtask

  initial
  begin
    repeat (20) @(posedge ref_clk);
    chk("rtt in reset", 32'h0, rtt_on);
    rst_n <= 1'b1;
    ahb(1'b0, 8'h00, 32'h0);
    chk("ctrl reset", 32'h0, rd);
    ahb(1'b0, 8'h04, 32'h0);
    chk("timing reset", 32'h05, rd);
    ahb(1'b0, 8'h08, 32'h0);
    chk("status reset", 32'h01, rd);
    foreach (rows[r])
    begin
      ahb(1'b1, rows[r].addr, rows[r].wdata);
      ahb(1'b0, rows[r].addr, 32'h0);
      chk("reg read", rows[r].rdata, rd);
      chk("link odt", rows[r].odt, dot_link_if_i.odt);
    end
    repeat (DLLK) @(posedge ref_clk);
    lat(32'h0, 3);
    @(posedge ref_clk);
    cwl <= 4'h6;
    al <= 4'h2;
    lat(32'h0, 6);
    @(posedge ref_clk);
    cwl <= 4'h5;
    al <= 4'h0;
    ahb(1'b1, 8'h00, 32'h2);
    wait_sig(2, 1'b1);
    chk("cke at entry", 32'h1, dot_link_if_i.cke);
    wait_sig(1, 1'b0);
    chk_cnt("entry length", 4, n);
    chk("entry end", 32'h0, dot_link_if_i.powerdown_entry_window);
    repeat (2) @(posedge ref_clk);
    chk("async in pd", 32'h1, async_mode);
    al <= 4'h2;
    lat(32'h2, 1);
    @(posedge ref_clk);
    al <= 4'h0;
    ahb(1'b1, 8'h00, 32'h0);
    wait_sig(3, 1'b1);
    chk("async in exit", 32'h1, async_mode);
    wait_sig(3, 1'b0);
    chk_cnt("exit length", 4 + XPD, n);
    chk("dram exit window", 32'h1, exit_window);
    repeat (2) @(posedge ref_clk);
    chk("sync after exit", 32'h0, async_mode);
    chk("dram exit end", 32'h0, exit_window);
    ahb(1'b1, 8'h00, 32'h4);
    ahb(1'b1, 8'h00, 32'h2);
    wait_sig(1, 1'b0);
    chk("entry held", 32'h1, dot_link_if_i.powerdown_entry_window);
    wait_sig(6, 1'b1);
    chk_cnt("dram entry delay", 1, n);
    wait_sig(2, 1'b0);
    chk_cnt("entry release", 1, n > 0 && n < RFC);
    chk("dram entry end", 32'h0, entry_window);
    ahb(1'b1, 8'h00, 32'h0);
    wait_sig(3, 1'b1);
    wait_sig(3, 1'b0);
    @(posedge ref_clk);
    dll_pd_keep <= 1'b1;
    win_seen = 0;
    ahb(1'b1, 8'h00, 32'ha);
    wait_sig(1, 1'b0);
    repeat (3) @(posedge ref_clk);
    chk("sync with keep", 32'h0, async_mode);
    ahb(1'b1, 8'h00, 32'h8);
    wait_sig(1, 1'b1);
    repeat (4) @(posedge ref_clk);
    chk_cnt("windows with keep", 0, win_seen);
    dll_pd_keep <= 1'b0;
    dll_reset <= 1'b1;
    @(posedge ref_clk);
    dll_reset <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk("async in relock", 32'h1, async_mode);
    repeat (DLLK + 4) @(posedge ref_clk);
    chk("sync after relock", 32'h0, async_mode);
    // refresh keeps entry open until cke is already rising again
    ahb(1'b1, 8'h00, 32'h4);
    ahb(1'b1, 8'h00, 32'h2);
    ahb(1'b1, 8'h00, 32'h0);
    wait_sig(6, 1'b1);
    wait_sig(3, 1'b1);
    chk("short low overlap", 32'h1, dot_link_if_i.powerdown_entry_window);
    wait_sig(6, 1'b0);
    chk("short low async", 32'h1, async_mode);
    chk("short low exit", 32'h1, exit_window);
    wait_sig(3, 1'b0);
    repeat (2) @(posedge ref_clk);
    chk("short low sync", 32'h0, async_mode);
    rtt_en <= 1'b0;
    ahb(1'b1, 8'h00, 32'h1);
    repeat (8) @(posedge ref_clk);
    chk("rtt when disabled", 32'h0, rtt_on);
    test_done();
  end
endmodule
